//--- pgpc_pkg.sv
package pgpc_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [15:0] PGPC_IDX_LO_OE = 16'h4400;
   localparam logic [15:0] PGPC_IDX_LO_DIR = 16'h4401;
   localparam logic [15:0] PGPC_IDX_LO_DAT = 16'h4402;
   localparam logic [15:0] PGPC_IDX_HI_OE = 16'h4403;
   localparam logic [15:0] PGPC_IDX_BUS_SEL = 16'h44f0;

   // Field positions and widths
   localparam int PGPC_PINS = 16;
   localparam int PGPC_MUX_BIT = 0;

   // Reset values
   localparam logic [15:0] PGPC_RST_LO_OE = 16'h0000;
   localparam logic [15:0] PGPC_RST_LO_DIR = 16'h0000;
   localparam logic [15:0] PGPC_RST_HI_OE = 16'h0000;
   localparam logic [15:0] PGPC_RST_LO_DAT = 16'h0000;
   localparam logic PGPC_RST_MUX = 1'b0;
   localparam logic [31:0] PGPC_RST_RDATA = 32'h0000_0000;

   // Edges after reset release until the synchronised pins are valid and loaded
   localparam logic [1:0] PGPC_INIT_COUNT = 2'h3;
   localparam logic [1:0] PGPC_INIT_LOAD = 2'h1;

   // AHB-Lite encodings
   localparam logic PGPC_HRESP_OKAY = 1'b0;

   typedef enum logic [5:0] {
      PGPC_SEL_NONE = 6'h01,
      PGPC_SEL_LO_OE = 6'h02,
      PGPC_SEL_LO_DIR = 6'h04,
      PGPC_SEL_LO_DAT = 6'h08,
      PGPC_SEL_HI_OE = 6'h10,
      PGPC_SEL_BUS_SEL = 6'h20
   } pgpc_sel_type;

   // Drive toward the low pins: level and active-low output enable
   typedef struct packed {
      logic [15:0] level;
      logic [15:0] oe_n;
   } pgpc_pin_drive_type;

   typedef struct packed {
      logic [15:0] lo_oe;
      logic [15:0] lo_dir;
      logic [15:0] lo_dat;
      logic [15:0] hi_oe;
      logic mux;
      logic [1:0] init;
      logic wr_pend;
      pgpc_sel_type sel;
      logic [31:0] rdata;
   } pgpc_state_type;

endpackage

//--- pgpc_sync.sv
`timescale 1ns/1ns
module pgpc_sync #(
   parameter int WIDTH = 16
) (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] async_in, // Levels from pins
   output logic [WIDTH-1:0] sync_out // Levels after two flip-flops
);

   typedef struct packed {
      logic [WIDTH-1:0] ff1;
      logic [WIDTH-1:0] ff2;
   } pgpc_sync_state_type;

   pgpc_sync_state_type state_reg;
   pgpc_sync_state_type state_next;

   if (WIDTH < 1) begin : g_bad_width
      $error("pgpc_sync: WIDTH must be at least 1");
   end

   always_comb begin
      state_next.ff1 = async_in;
      state_next.ff2 = state_reg.ff1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.ff2;

endmodule // pgpc_sync

//--- pgpc_gpio.sv
`timescale 1ns/1ns
// Behaviour
// - Direction 0: data bit follows the sampled pin level.
// - Direction 1: data bit is the level driven onto the pin.
// - Low direction register: 16 RW bits, reset zero, index 0x4401.
// - Input pin: data bit reads 0 for low, 1 for high.
// - Output pin: writing data 0 drives low, 1 drives high.
// - After reset each data bit takes its pin's level.
// - Output enable 0: driver off, pin is input only.
// - Output enable 1: driver on.
// - High output-enable register: 16 RW bits pins 16-31, index 0x4403, reset zero.
// - Low output-enable register: 16 RW bits, index 0x4400, reset zero.
// - Pins act as GPIO only while bus-selection mux mode is cleared.
// - Mux mode has priority; enables cannot reclaim memory-interface pins.
module pgpc_gpio (
   input wire logic hclk, // Bus clock, 50 MHz
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready in
   output logic hreadyout, // Ready out, never stalls
   output logic hresp, // Response, always OKAY
   output logic [31:0] hrdata, // Read data
   input wire logic [15:0] lo_pin_in, // Levels on pins 0-15
   output pgpc_pkg::pgpc_pin_drive_type lo_pin_out, // Level and oe_n for pins 0-15
   output logic [15:0] hi_pin_oe_n, // Output enable for pins 16-31, active low
   output logic mux_mode // Pins belong to the memory interface
);

   pgpc_pkg::pgpc_state_type s_reg;
   pgpc_pkg::pgpc_state_type s_next;
   logic [15:0] pin_sync;
   logic addr_phase;

   pgpc_sync #(
      .WIDTH(pgpc_pkg::PGPC_PINS)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(lo_pin_in),
      .sync_out(pin_sync)
   );

   function automatic logic [31:0] byte_addr(input logic [15:0] idx);
      byte_addr = {14'h0000, idx, 2'b00};
   endfunction

   function automatic pgpc_pkg::pgpc_sel_type decode(input logic [31:0] addr);
      if (addr == byte_addr(pgpc_pkg::PGPC_IDX_LO_OE)) begin
         decode = pgpc_pkg::PGPC_SEL_LO_OE;
      end else if (addr == byte_addr(pgpc_pkg::PGPC_IDX_LO_DIR)) begin
         decode = pgpc_pkg::PGPC_SEL_LO_DIR;
      end else if (addr == byte_addr(pgpc_pkg::PGPC_IDX_LO_DAT)) begin
         decode = pgpc_pkg::PGPC_SEL_LO_DAT;
      end else if (addr == byte_addr(pgpc_pkg::PGPC_IDX_HI_OE)) begin
         decode = pgpc_pkg::PGPC_SEL_HI_OE;
      end else if (addr == byte_addr(pgpc_pkg::PGPC_IDX_BUS_SEL)) begin
         decode = pgpc_pkg::PGPC_SEL_BUS_SEL;
      end else begin
         decode = pgpc_pkg::PGPC_SEL_NONE;
      end
   endfunction

   function automatic logic [31:0] read_reg(input pgpc_pkg::pgpc_state_type st,
                                            input pgpc_pkg::pgpc_sel_type sel);
      read_reg = 32'h0000_0000;
      unique case (sel)
         pgpc_pkg::PGPC_SEL_LO_OE: begin
            read_reg[15:0] = st.lo_oe;
         end
         pgpc_pkg::PGPC_SEL_LO_DIR: begin
            read_reg[15:0] = st.lo_dir;
         end
         pgpc_pkg::PGPC_SEL_LO_DAT: begin
            read_reg[15:0] = st.lo_dat;
         end
         pgpc_pkg::PGPC_SEL_HI_OE: begin
            read_reg[15:0] = st.hi_oe;
         end
         pgpc_pkg::PGPC_SEL_BUS_SEL: begin
            read_reg[pgpc_pkg::PGPC_MUX_BIT] = st.mux;
         end
         default: begin
            read_reg = 32'h0000_0000;
         end
      endcase
   endfunction

   assign addr_phase = hsel && htrans[1] && hready;

   always_comb begin
      s_next = s_reg;
      if (s_reg.init != 2'h0) begin
         s_next.init = s_reg.init - 2'h1;
      end
      // Data phase of a write lands here; unmapped addresses are dropped
      if (s_reg.wr_pend) begin
         unique case (s_reg.sel)
            pgpc_pkg::PGPC_SEL_LO_OE: begin
               s_next.lo_oe = hwdata[15:0];
            end
            pgpc_pkg::PGPC_SEL_LO_DIR: begin
               s_next.lo_dir = hwdata[15:0];
            end
            pgpc_pkg::PGPC_SEL_LO_DAT: begin
               s_next.lo_dat = hwdata[15:0];
            end
            pgpc_pkg::PGPC_SEL_HI_OE: begin
               s_next.hi_oe = hwdata[15:0];
            end
            pgpc_pkg::PGPC_SEL_BUS_SEL: begin
               s_next.mux = hwdata[pgpc_pkg::PGPC_MUX_BIT];
            end
            default: begin
               s_next.mux = s_reg.mux;
            end
         endcase
      end
      // Input bits track the pins while mux is clear; the pin level wins over a data write
      if (s_reg.init == pgpc_pkg::PGPC_INIT_LOAD) begin
         s_next.lo_dat = pin_sync;
      end else if (!s_next.mux) begin
         s_next.lo_dat = (s_next.lo_dat & s_next.lo_dir) | (pin_sync & ~s_next.lo_dir);
      end
      s_next.wr_pend = addr_phase && hwrite;
      s_next.sel = addr_phase ? decode(haddr) : pgpc_pkg::PGPC_SEL_NONE;
      // Read data taken from the next state so a read right after a write sees it
      if (addr_phase && !hwrite) begin
         s_next.rdata = read_reg(s_next, decode(haddr));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg.lo_oe <= pgpc_pkg::PGPC_RST_LO_OE;
         s_reg.lo_dir <= pgpc_pkg::PGPC_RST_LO_DIR;
         s_reg.lo_dat <= pgpc_pkg::PGPC_RST_LO_DAT;
         s_reg.hi_oe <= pgpc_pkg::PGPC_RST_HI_OE;
         s_reg.mux <= pgpc_pkg::PGPC_RST_MUX;
         s_reg.init <= pgpc_pkg::PGPC_INIT_COUNT;
         s_reg.wr_pend <= 1'b0;
         s_reg.sel <= pgpc_pkg::PGPC_SEL_NONE;
         s_reg.rdata <= pgpc_pkg::PGPC_RST_RDATA;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = pgpc_pkg::PGPC_HRESP_OKAY;
   assign hrdata = s_reg.rdata;
   assign mux_mode = s_reg.mux;
   // Mux mode overrides every enable; driver on only when enable bit set
   assign lo_pin_out.level = s_reg.lo_dat;
   assign lo_pin_out.oe_n = ~(s_reg.lo_oe & {16{~s_reg.mux}});
   assign hi_pin_oe_n = ~(s_reg.hi_oe & {16{~s_reg.mux}});

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence seq_wr_addr(logic [15:0] idx);
      hsel && htrans[1] && hready && hwrite && haddr == byte_addr(idx);
   endsequence

   sequence seq_rd_addr(logic [15:0] idx);
      hsel && htrans[1] && hready && !hwrite && haddr == byte_addr(idx);
   endsequence

   sequence seq_idle_phase;
      !(hsel && htrans[1]);
   endsequence

   AST_DIR_INPUT_FOLLOWS_PIN: assert property (
      (s_reg.init == 2'h0 && !s_reg.mux && $past(!s_reg.mux))
      |-> (((s_reg.lo_dat ^ $past(pin_sync)) & ~s_reg.lo_dir) == 16'h0000))
      else $error("Input data bit does not follow the pin");

   AST_OUTPUT_LEVEL_FROM_DATA: assert property (
      ((lo_pin_out.level ^ s_reg.lo_dat) & s_reg.lo_dir) == 16'h0000
      && (s_reg.lo_oe & s_reg.lo_dir & ~s_reg.lo_dat & lo_pin_out.level) == 16'h0000)
      else $error("Driven level differs from data bit");

   AST_DIR_WRITE_STORES: assert property (
      seq_wr_addr(pgpc_pkg::PGPC_IDX_LO_DIR) ##1 seq_idle_phase
      |=> s_reg.lo_dir == $past(hwdata[15:0]))
      else $error("Direction write not stored");

   AST_INPUT_READ_LEVEL: assert property (
      (s_reg.init == 2'h0 && !s_reg.mux && s_reg.lo_dir == 16'h0000 && !s_reg.wr_pend)
      ##0 seq_rd_addr(pgpc_pkg::PGPC_IDX_LO_DAT)
      |=> hrdata[15:0] == $past(pin_sync) && hrdata[31:16] == 16'h0000)
      else $error("Input read does not return pin level");

   AST_OUTPUT_WRITE_DRIVES: assert property (
      (s_reg.lo_dir == 16'hffff && s_reg.lo_oe == 16'hffff && !s_reg.mux)
      ##0 seq_wr_addr(pgpc_pkg::PGPC_IDX_LO_DAT) ##1 seq_idle_phase
      |=> lo_pin_out.level == $past(hwdata[15:0]) && lo_pin_out.oe_n == 16'h0000)
      else $error("Output write not driven on pins");

   AST_RESET_LOADS_PIN: assert property (
      s_reg.init == pgpc_pkg::PGPC_INIT_LOAD |=> s_reg.lo_dat == $past(pin_sync))
      else $error("Data register not loaded from pins after reset");

   AST_OE_OFF_NO_DRIVE: assert property (
      (~s_reg.lo_oe & ~lo_pin_out.oe_n) == 16'h0000
      && (~s_reg.hi_oe & ~hi_pin_oe_n) == 16'h0000)
      else $error("Pin driven with enable clear");

   AST_OE_ON_DRIVES: assert property (
      seq_wr_addr(pgpc_pkg::PGPC_IDX_LO_OE) ##1 (seq_idle_phase and !s_reg.mux)
      |=> lo_pin_out.oe_n == ~$past(hwdata[15:0]))
      else $error("Low enable write not reflected on drivers");

   AST_HI_OE_WRITE: assert property (
      seq_wr_addr(pgpc_pkg::PGPC_IDX_HI_OE) ##1 (seq_idle_phase and !s_reg.mux)
      |=> hi_pin_oe_n == ~$past(hwdata[15:0]) && s_reg.hi_oe == $past(hwdata[15:0]))
      else $error("High enable write not applied");

   AST_LO_OE_RESET_CLEAR: assert property (
      s_reg.init == pgpc_pkg::PGPC_INIT_COUNT
      |-> s_reg.lo_oe == 16'h0000 && s_reg.hi_oe == 16'h0000 && s_reg.lo_dir == 16'h0000)
      else $error("Enable or direction not clear after reset");

   AST_MUX_FREEZES_DATA: assert property (
      (s_reg.mux && s_reg.init == 2'h0 && !s_reg.wr_pend) |=> $stable(s_reg.lo_dat))
      else $error("Data register moves while pins belong to the memory interface");

   AST_MUX_PRIORITY: assert property (
      s_reg.mux |-> lo_pin_out.oe_n == 16'hffff && hi_pin_oe_n == 16'hffff)
      else $error("Enable reclaimed a memory-interface pin");

   AST_DIR_READ_BACK: assert property (
      seq_wr_addr(pgpc_pkg::PGPC_IDX_LO_DIR) ##1 seq_idle_phase
      ##1 seq_rd_addr(pgpc_pkg::PGPC_IDX_LO_DIR)
      |=> hrdata[15:0] == $past(hwdata[15:0], 2) && $stable(s_reg.lo_oe))
      else $error("Direction read-back wrong or had a side effect");

   AST_HREADY_OKAY: assert property (
      hreadyout && hresp == pgpc_pkg::PGPC_HRESP_OKAY)
      else $error("Slave stalled or answered with an error");

endmodule // pgpc_gpio

//--- pgpc_pins_model.sv
`timescale 1ns/1ns
module pgpc_pins_model (
   input wire logic [15:0] board_level, // Level the board applies to released pins
   input wire pgpc_pkg::pgpc_pin_drive_type lo_pin_out, // Drive from the device
   output logic [15:0] lo_pin_in // Resolved levels on pins 0-15
);
   // The device wins where its driver is on; the board holds every released pin
   assign lo_pin_in = (lo_pin_out.oe_n & board_level) | (~lo_pin_out.oe_n & lo_pin_out.level);
endmodule // pgpc_pins_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mux_mode;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] lo_pin_in, hi_pin_oe_n, board_level;
   logic [15:0] m_dir, m_dat, m_hi;
   pgpc_pkg::pgpc_pin_drive_type lo_pin_out;
   integer num_errors = 0;
   integer n_compared = 0;
   integer seed = 32'h88d2;
   integer i;

   pgpc_gpio pgpc_gpio_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .lo_pin_in(lo_pin_in),
      .lo_pin_out(lo_pin_out),
      .hi_pin_oe_n(hi_pin_oe_n),
      .mux_mode(mux_mode)
   );

   pgpc_pins_model pgpc_pins_model_inst (
      .board_level(board_level),
      .lo_pin_out(lo_pin_out),
      .lo_pin_in(lo_pin_in)
   );

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single transfer; for a read, d is the expected word
   task bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {14'h0000, idx, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      chk({31'h0, hresp}, {31'h0, pgpc_pkg::PGPC_HRESP_OKAY});
      if (!wr) begin
         chk(hrdata, d);
      end
   endtask

   task finish_test;
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      num_errors = num_errors + 1;
      finish_test;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      board_level = 16'ha5c3;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_OE, 32'h0000_0000);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DIR, 32'h0000_0000);
      bus(1'b0, pgpc_pkg::PGPC_IDX_HI_OE, 32'h0000_0000);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DAT, 32'h0000_a5c3);
      chk({16'h0000, lo_pin_out.oe_n}, 32'h0000_ffff);
      // Unmapped word: write dropped, read gives zero
      bus(1'b1, 16'h4410, 32'hffff_ffff);
      bus(1'b0, 16'h4410, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         rd = $random(seed);
         board_level <= rd[31:16];
         m_dir = rd[15:0];
         // Enable and direction always written equal
         bus(1'b1, pgpc_pkg::PGPC_IDX_LO_DIR, rd);
         bus(1'b1, pgpc_pkg::PGPC_IDX_LO_OE, rd);
         rd = $random(seed);
         m_hi = rd[15:0];
         bus(1'b1, pgpc_pkg::PGPC_IDX_HI_OE, rd);
         rd = $random(seed);
         m_dat = rd[15:0];
         bus(1'b1, pgpc_pkg::PGPC_IDX_LO_DAT, rd);
         // Three edges through the synchroniser before input bits settle
         repeat (4) @(posedge hclk);
         bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DIR, {16'h0000, m_dir});
         bus(1'b0, pgpc_pkg::PGPC_IDX_LO_OE, {16'h0000, m_dir});
         bus(1'b0, pgpc_pkg::PGPC_IDX_HI_OE, {16'h0000, m_hi});
         bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DAT, {16'h0000, (m_dat & m_dir) | (board_level & ~m_dir)});
         chk({16'h0000, lo_pin_out.oe_n}, {16'h0000, ~m_dir});
         chk({16'h0000, lo_pin_out.level & m_dir}, {16'h0000, m_dat & m_dir});
         chk({16'h0000, lo_pin_in & m_dir}, {16'h0000, m_dat & m_dir});
         chk({16'h0000, hi_pin_oe_n}, {16'h0000, ~m_hi});
      end
      // Every low pin an output: direction read-back, then driven data
      bus(1'b1, pgpc_pkg::PGPC_IDX_LO_DIR, 32'h0000_ffff);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DIR, 32'h0000_ffff);
      bus(1'b1, pgpc_pkg::PGPC_IDX_LO_OE, 32'h0000_ffff);
      rd = $random(seed);
      m_dat = rd[15:0];
      bus(1'b1, pgpc_pkg::PGPC_IDX_LO_DAT, rd);
      @(posedge hclk);
      chk({16'h0000, lo_pin_in}, {16'h0000, m_dat});
      chk({16'h0000, lo_pin_out.oe_n}, 32'h0000_0000);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DAT, {16'h0000, m_dat});
      // Back to all inputs and let the pins settle before the mux is taken
      bus(1'b1, pgpc_pkg::PGPC_IDX_LO_DIR, 32'h0000_0000);
      bus(1'b1, pgpc_pkg::PGPC_IDX_LO_OE, 32'h0000_0000);
      m_dir = 16'h0000;
      repeat (4) @(posedge hclk);
      m_dat = board_level;
      bus(1'b1, pgpc_pkg::PGPC_IDX_BUS_SEL, 32'h0000_0001);
      bus(1'b1, pgpc_pkg::PGPC_IDX_HI_OE, 32'h0000_ffff);
      repeat (2) @(posedge hclk);
      chk({31'h0, mux_mode}, 32'h0000_0001);
      chk({16'h0000, lo_pin_out.oe_n}, 32'h0000_ffff);
      chk({16'h0000, hi_pin_oe_n}, 32'h0000_ffff);
      bus(1'b0, pgpc_pkg::PGPC_IDX_BUS_SEL, 32'h0000_0001);
      bus(1'b0, pgpc_pkg::PGPC_IDX_HI_OE, 32'h0000_ffff);
      // Pins move while the mux owns them; the data register must hold
      board_level <= ~m_dat;
      repeat (4) @(posedge hclk);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DAT, {16'h0000, m_dat});
      bus(1'b1, pgpc_pkg::PGPC_IDX_BUS_SEL, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      bus(1'b0, pgpc_pkg::PGPC_IDX_LO_DAT, {16'h0000, ~m_dat});
      chk({31'h0, mux_mode}, 32'h0000_0000);
      chk({16'h0000, hi_pin_oe_n}, 32'h0000_0000);
      chk({16'h0000, lo_pin_out.oe_n}, {16'h0000, ~m_dir});
      finish_test;
   end
endmodule // tb_top
